/* File: hdl/psq_grade_map.sv */
// Purpose: Map a 10-bit receiver mean square error to a 3-bit quality grade.
// Assumes: Purely combinational; the caller registers the result.
// Notes:   Grade counts the limits that the error does not exceed.
`timescale 1ns/1ps
module psq_grade_map
	import psq_pkg::*;
(
	// Error in, grade out
	input  wire logic [psq_pkg::MSE_W-1:0]   mse,
	output logic      [psq_pkg::GRADE_W-1:0] grade
);

	// R9 grade from limits
	always_comb
	begin
		grade = GRADE_ZERO;
		for (int i = 0; i < NUM_LIM; i++)
		begin
			if (mse <= MSE_LIM[i])
				grade = GRADE_W'(i + 1);
		end
	end

endmodule

/* File: hdl/psq_stats_monitor.sv */
// Purpose: Packet statistics counters and link quality reporting behind a register port.
// Assumes: Event and sample inputs come from logic on the same clock; reads answer one cycle later.
// Notes:   Counters wrap; a count event in the clearing cycle survives as a count of one.
`timescale 1ns/1ps

// How it works
// R1 - The low 16 bits of the transmit packet counter read back at the first transmit statistics address.
// R2 - The high 16 bits of that counter read back at the next address.
// R3 - Transmitted packets with a CRC error are counted in a full 16-bit register.
// R4 - Reading transmit low, high and error registers in that order clears all three transmit registers.
// R5 - The low 16 bits of the receive packet counter read back at the first receive statistics address.
// R6 - The high 16 bits of that counter read back at the following address.
// R7 - Received packets failing the CRC check are counted in a 16-bit register.
// R8 - Reading receive low, high and error registers in that order clears all three receive registers.
// R9 - The 10-bit error maps to a 3-bit grade by seven inclusive upper limits, from 102 down to 25.
// R10 - The worst grade since the last read is held in bits 7 to 5 and cleared by reading it.
// R11 - An 8-bit peak error value, scaled by the signal processor, is reported as it arrives.
// R12 - The largest peak error since the last read is held in bits 15 to 8 and cleared by reading it.
// R13 - The 10-bit mean square error is readable in the low bits of its own register.
// R14 - Software drops the leading space-marker nibble when addressing the medium control register.
// R15 - Writing one to bit 15 of medium control resets the attach logic until it reports completion.
// R16 - Reserved bits read as zero and writes to them are ignored.
module psq_stats_monitor
	import psq_pkg::*;
(
	// Clock and reset
	input  wire logic                        clock,
	input  wire logic                        resetn,
	// Register access
	input  wire logic [psq_pkg::ADDR_W-1:0]  regAddr,
	input  wire logic                        regRead,
	input  wire logic                        regWrite,
	input  wire logic [psq_pkg::DATA_W-1:0]  regWdata,
	output logic      [psq_pkg::DATA_W-1:0]  regRdata,
	output logic                             regRdValid,
	// Packet events
	input  wire logic                        txPacket,
	input  wire logic                        txCrcError,
	input  wire logic                        rxPacket,
	input  wire logic                        rxCrcError,
	// Error samples from the signal processor
	input  wire logic                        mseValid,
	input  wire logic [psq_pkg::MSE_W-1:0]   mseSample,
	input  wire logic [psq_pkg::PEAK_W-1:0]  peakMseSample,
	// Medium attach reset
	input  wire logic                        mediumResetDone,
	output logic                             mediumReset
);

	logic [NUM_GRP-1:0] pktEvent;
	logic [NUM_GRP-1:0] errEvent;
	logic [NUM_GRP-1:0] rdLow;
	logic [NUM_GRP-1:0] rdHigh;
	logic [NUM_GRP-1:0] rdErr;
	logic [NUM_GRP-1:0] groupClear;
	logic [PKT_W-1:0]   pktCount [NUM_GRP];
	logic [ERR_W-1:0]   errCount [NUM_GRP];
	psq_seq_t           seqState [NUM_GRP];
	logic [MSE_W-1:0]   mseLock;
	logic [PEAK_W-1:0]  peakMse;
	logic [PEAK_W-1:0]  worstPeak;
	logic [GRADE_W-1:0] grade;
	logic [GRADE_W-1:0] worstGrade;
	logic               worstSeen;
	logic [GRADE_W-1:0] sampleGrade;
	logic               rdGrade;
	logic               rdPeak;
	logic               wrMedium;
	logic [DATA_W-1:0]  next_rdata;

	// Event vectors indexed by group
	assign pktEvent = {rxPacket, txPacket};
	assign errEvent = {rxCrcError, txCrcError};

	// Quality register decodes
	assign rdGrade = regRead && (regAddr == ADDR_GRADE);
	assign rdPeak  = regRead && (regAddr == ADDR_PEAK);
	// R14 nibble-free medium address
	assign wrMedium = regWrite && (regAddr == ADDR_MEDIUM);

	// R9 grade of the incoming sample, registered with the sample itself
	psq_grade_map u_grade_map
	(
		.mse   (mseSample),
		.grade (sampleGrade)
	);

	// One statistics group per direction
	for (genvar g = 0; g < NUM_GRP; g++)
	begin : gen_grp
		assign rdLow[g]  = regRead && (regAddr == GRP_LOW[g]);
		assign rdHigh[g] = regRead && (regAddr == GRP_HIGH[g]);
		assign rdErr[g]  = regRead && (regAddr == GRP_ERR[g]);
		// R4 R8 clear on completed sequence
		assign groupClear[g] = rdErr[g] && (seqState[g] == SEQ_HIGH);

		// Track low, high, error reads; any break in order starts over
		always_ff @(posedge clock or negedge resetn)
		begin
			if (!resetn)
				seqState[g] <= SEQ_IDLE;
			else if (rdLow[g])
				seqState[g] <= SEQ_LOW;
			else
			begin
				case (seqState[g])
					SEQ_IDLE:
						seqState[g] <= SEQ_IDLE;
					SEQ_LOW:
						if (rdErr[g])
							seqState[g] <= SEQ_IDLE;
						else if (rdHigh[g])
							seqState[g] <= SEQ_HIGH;
					SEQ_HIGH:
						if (rdErr[g] || rdHigh[g])
							seqState[g] <= SEQ_IDLE;
					default:
						seqState[g] <= SEQ_IDLE;
				endcase
			end
		end

		// R1 R5 packet counter, event wins over clear
		always_ff @(posedge clock or negedge resetn)
		begin
			if (!resetn)
				pktCount[g] <= PKT_ZERO;
			else if (groupClear[g])
				pktCount[g] <= pktEvent[g] ? PKT_ONE : PKT_ZERO;
			else if (pktEvent[g])
				pktCount[g] <= pktCount[g] + PKT_ONE;
		end

		// R3 R7 CRC error counter, event wins over clear
		always_ff @(posedge clock or negedge resetn)
		begin
			if (!resetn)
				errCount[g] <= ERR_ZERO;
			else if (groupClear[g])
				errCount[g] <= errEvent[g] ? ERR_ONE : ERR_ZERO;
			else if (errEvent[g])
				errCount[g] <= errCount[g] + ERR_ONE;
		end
	end

	// R13 R11 latest error samples and grade
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			mseLock <= MSE_ZERO;
			peakMse <= PEAK_ZERO;
			grade   <= GRADE_ZERO;
		end
		else if (mseValid)
		begin
			mseLock <= mseSample;
			peakMse <= peakMseSample;
			grade   <= sampleGrade;
		end
	end

	// R10 worst grade since read; a fresh sample wins over the read clear
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			worstGrade <= GRADE_ZERO;
			worstSeen  <= 1'b0;
		end
		else if (mseValid && (rdGrade || !worstSeen || sampleGrade < worstGrade))
		begin
			worstGrade <= sampleGrade;
			worstSeen  <= 1'b1;
		end
		else if (rdGrade)
		begin
			worstGrade <= GRADE_ZERO;
			worstSeen  <= 1'b0;
		end
	end

	// R12 worst peak since read; zero is the natural empty value for a maximum
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			worstPeak <= PEAK_ZERO;
		else if (mseValid && (rdPeak || peakMseSample > worstPeak))
			worstPeak <= peakMseSample;
		else if (rdPeak)
			worstPeak <= PEAK_ZERO;
	end

	// R15 self-clearing attach reset; a write of zero cannot abort it
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			mediumReset <= 1'b0;
		else if (wrMedium && regWdata[MED_RESET_BIT])
			mediumReset <= 1'b1;
		else if (mediumResetDone)
			mediumReset <= 1'b0;
	end

	// R2 R6 high halves are read live, so a carry between two reads shows up
	// R16 read mux, reserved bits and unmapped addresses give zero
	always_comb
	begin
		next_rdata = DATA_ZERO;
		case (regAddr)
			ADDR_TX_LOW:  next_rdata = pktCount[GRP_TX][DATA_W-1:0];
			ADDR_TX_HIGH: next_rdata = pktCount[GRP_TX][PKT_W-1:DATA_W];
			ADDR_TX_ERR:  next_rdata = errCount[GRP_TX];
			ADDR_RX_LOW:  next_rdata = pktCount[GRP_RX][DATA_W-1:0];
			ADDR_RX_HIGH: next_rdata = pktCount[GRP_RX][PKT_W-1:DATA_W];
			ADDR_RX_ERR:  next_rdata = errCount[GRP_RX];
			ADDR_GRADE:
			begin
				next_rdata[GRADE_LSB +: GRADE_W]       = grade;
				next_rdata[WORST_GRADE_LSB +: GRADE_W] = worstGrade;
			end
			ADDR_PEAK:
			begin
				next_rdata[PEAK_LSB +: PEAK_W]       = peakMse;
				next_rdata[WORST_PEAK_LSB +: PEAK_W] = worstPeak;
			end
			ADDR_MSE:     next_rdata[MSE_W-1:0] = mseLock;
			ADDR_MEDIUM:  next_rdata[MED_RESET_BIT] = mediumReset;
			default:      next_rdata = DATA_ZERO;
		endcase
	end

	// Registered answer; data stays zero between reads to keep the bus quiet
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			regRdata   <= DATA_ZERO;
			regRdValid <= 1'b0;
		end
		else
		begin
			regRdata   <= regRead ? next_rdata : DATA_ZERO;
			regRdValid <= regRead;
		end
	end

	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	logic [DATA_W-1:0] txHighHalf;
	assign txHighHalf = pktCount[GRP_TX][PKT_W-1:DATA_W];

	// Read answer: one cycle after the strobe, quiet otherwise
	a_read_answer: assert property (regRead |=> regRdValid) // R16
		else $error("read answer missing");
	a_read_quiet: assert property (!regRead |=> !regRdValid && regRdata == DATA_ZERO) // R16
		else $error("read data not quiet between reads");

	// Counter, sequence, quality, medium and reserved bit checks
	a_tx_count_step: assert property (txPacket && !groupClear[GRP_TX] // R1
		|=> pktCount[GRP_TX] == $past(pktCount[GRP_TX]) + PKT_ONE)
		else $error("tx packet counter did not step");
	a_tx_high_read: assert property (regRead && regAddr == ADDR_TX_HIGH |=> regRdata == $past(txHighHalf)) // R2
		else $error("tx high half read wrong");
	a_tx_seq_clear: assert property (regRead && regAddr == ADDR_TX_ERR && seqState[GRP_TX] == SEQ_HIGH // R4
		&& !txPacket && !txCrcError |=> pktCount[GRP_TX] == PKT_ZERO && errCount[GRP_TX] == ERR_ZERO)
		else $error("tx counters not cleared by sequence");
	a_rx_high_read: assert property (regRead && regAddr == ADDR_RX_HIGH // R6
		|=> regRdata == $past(pktCount[GRP_RX][PKT_W-1:DATA_W]))
		else $error("rx high half read wrong");
	a_rx_err_step: assert property (rxCrcError && !groupClear[GRP_RX] // R7
		|=> errCount[GRP_RX] == $past(errCount[GRP_RX]) + ERR_ONE)
		else $error("rx error counter did not step");
	a_rx_seq_clear: assert property (rdLow[GRP_RX] ##1 rdHigh[GRP_RX] // R8
		##1 (rdErr[GRP_RX] && !rxPacket && !rxCrcError)
		|=> pktCount[GRP_RX] == PKT_ZERO && errCount[GRP_RX] == ERR_ZERO)
		else $error("rx counters not cleared by sequence");
	a_grade_best: assert property (mseValid && mseSample <= MSE_LIM[NUM_LIM-1] |=> grade == GRADE_BEST) // R9
		else $error("low error did not give best grade");
	a_grade_worst: assert property (mseValid && mseSample > MSE_LIM[0] |=> grade == GRADE_ZERO) // R9
		else $error("high error did not give worst grade");
	a_worst_grade_min: assert property (worstSeen && mseValid && !rdGrade |=> worstGrade <= grade) // R10
		else $error("worst grade above current grade");
	a_peak_read_clear: assert property (rdPeak && !mseValid |=> worstPeak == PEAK_ZERO) // R12
		else $error("worst peak not cleared by read");
	a_mse_read: assert property (regRead && regAddr == ADDR_MSE |=> regRdata[MSE_W-1:0] == $past(mseLock)) // R13
		else $error("mse read wrong");
	a_medium_reset: assert property (wrMedium && regWdata[MED_RESET_BIT] |=> mediumReset) // R15
		else $error("attach reset not raised");
	a_medium_release: assert property (mediumReset && mediumResetDone && !(wrMedium && regWdata[MED_RESET_BIT]) // R15
		|=> !mediumReset)
		else $error("attach reset did not clear itself");
	a_reserved_zero: assert property (rdGrade |=> regRdata[0] == 1'b0 && regRdata[4] == 1'b0 // R16
		&& regRdata[DATA_W-1:WORST_PEAK_LSB] == PEAK_ZERO)
		else $error("reserved grade bits not zero");

	// Main scenarios; the bench reaches all but c_worst_drop
	c_tx_clear: cover property (groupClear[GRP_TX]);
	c_rx_clear: cover property (groupClear[GRP_RX]);
	c_medium_done: cover property (mediumReset ##1 !mediumReset);
	c_worst_drop: cover property (mseValid && worstSeen && sampleGrade < worstGrade);
	c_back_to_back: cover property (regRead ##1 regRead);

endmodule

/* File: include/psq_pkg.sv */
// Purpose: Shared constants and types for the packet statistics and link quality monitor.
// Assumes: 16-bit register words reached by address, one register per address.
// Notes:   All offsets, field positions and grade limits live here.
package psq_pkg;

	// Widths
	localparam int ADDR_W  = 16;
	localparam int DATA_W  = 16;
	localparam int MSE_W   = 10;
	localparam int PEAK_W  = 8;
	localparam int GRADE_W = 3;
	localparam int PKT_W   = 32;
	localparam int ERR_W   = 16;
	localparam int NUM_GRP = 2;
	localparam int GRP_TX  = 0;
	localparam int GRP_RX  = 1;
	localparam int NUM_LIM = 7;

	// Register offsets
	localparam logic [ADDR_W-1:0] ADDR_TX_LOW  = 16'h0639;
	localparam logic [ADDR_W-1:0] ADDR_TX_HIGH = 16'h063a;
	localparam logic [ADDR_W-1:0] ADDR_TX_ERR  = 16'h063b;
	localparam logic [ADDR_W-1:0] ADDR_RX_LOW  = 16'h063c;
	localparam logic [ADDR_W-1:0] ADDR_RX_HIGH = 16'h063d;
	localparam logic [ADDR_W-1:0] ADDR_RX_ERR  = 16'h063e;
	localparam logic [ADDR_W-1:0] ADDR_GRADE   = 16'h0871;
	localparam logic [ADDR_W-1:0] ADDR_PEAK    = 16'h0874;
	localparam logic [ADDR_W-1:0] ADDR_MSE     = 16'h0875;
	// Medium control is printed with the space-marker nibble, which the access drops
	localparam logic [ADDR_W-1:0] ADDR_MEDIUM_PRINTED = 16'h1000;
	localparam logic [ADDR_W-1:0] MMD_NIBBLE_MASK     = 16'h0fff;
	localparam logic [ADDR_W-1:0] ADDR_MEDIUM         = ADDR_MEDIUM_PRINTED & MMD_NIBBLE_MASK;

	// Per-group address tables
	localparam logic [ADDR_W-1:0] GRP_LOW  [NUM_GRP] = '{ADDR_TX_LOW, ADDR_RX_LOW};
	localparam logic [ADDR_W-1:0] GRP_HIGH [NUM_GRP] = '{ADDR_TX_HIGH, ADDR_RX_HIGH};
	localparam logic [ADDR_W-1:0] GRP_ERR  [NUM_GRP] = '{ADDR_TX_ERR, ADDR_RX_ERR};

	// Field positions
	localparam int GRADE_LSB       = 1;
	localparam int WORST_GRADE_LSB = 5;
	localparam int PEAK_LSB        = 0;
	localparam int WORST_PEAK_LSB  = 8;
	localparam int MED_RESET_BIT   = 15;

	// Reset values, unit steps and the best grade
	localparam logic [DATA_W-1:0]  DATA_ZERO  = 16'h0000;
	localparam logic [PKT_W-1:0]   PKT_ZERO   = 32'h0000_0000;
	localparam logic [PKT_W-1:0]   PKT_ONE    = 32'h0000_0001;
	localparam logic [ERR_W-1:0]   ERR_ZERO   = 16'h0000;
	localparam logic [ERR_W-1:0]   ERR_ONE    = 16'h0001;
	localparam logic [MSE_W-1:0]   MSE_ZERO   = 10'h000;
	localparam logic [PEAK_W-1:0]  PEAK_ZERO  = 8'h00;
	localparam logic [GRADE_W-1:0] GRADE_ZERO = 3'h0;
	localparam logic [GRADE_W-1:0] GRADE_BEST = 3'h7;

	// Grade limits, each an inclusive upper bound, worst to best
	localparam logic [MSE_W-1:0] MSE_LIM [NUM_LIM] =
		'{10'h066, 10'h051, 10'h041, 10'h033, 10'h029, 10'h020, 10'h019};

	// Read sequence tracker, Gray coded from idle through low to high
	typedef enum logic [1:0]
	{
		SEQ_IDLE = 2'b00,
		SEQ_LOW  = 2'b01,
		SEQ_HIGH = 2'b11
	} psq_seq_t;

endpackage

/* File: test/psq_attach_model.sv */
// Purpose: Stand-in for the medium attach logic that answers the attach reset.
// Assumes: Same clock as the monitor; done is a level while the reset is held.
// Notes:   Delay of zero answers at once, larger values model a slow attach.
`timescale 1ns/1ps
module psq_attach_model
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       resetn,
	// Attach reset handshake
	input  wire logic       mediumReset,
	input  wire logic [7:0] delayCycles,
	output logic            mediumResetDone
);
	logic [7:0] holdCount;

	// Count cycles of asserted reset; restart whenever it drops
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			holdCount <= 8'h00;
		else if (!mediumReset)
			holdCount <= 8'h00;
		else if (holdCount < delayCycles)
			holdCount <= holdCount + 8'h01;
	end

	assign mediumResetDone = mediumReset && (holdCount >= delayCycles); // Low outside a reset, never stale
endmodule

/* File: test/testbench.sv */
// Purpose: Self-checking bench for the statistics and link quality monitor.
// Assumes: Inputs change 1 ns after the rising edge; reads answer one cycle later.
// Notes:   The transmit run wraps the low 16-bit half and the error counter, so it is the long part of the run.
`timescale 1ns/1ps
module testbench;
	import psq_pkg::*;

	logic        clock, resetn, regRead, regWrite, regRdValid;
	logic [15:0] regAddr, regWdata, regRdata;
	logic        txPacket, txCrcError, rxPacket, rxCrcError, mseValid;
	logic [9:0]  mseSample;
	logic [7:0]  peakMseSample, attachDelay;
	logic        mediumResetDone, mediumReset;
	int          miscompares, checked;
	int          mseList [14] = '{25, 26, 32, 33, 41, 42, 51, 52, 65, 66, 81, 82, 102, 103};
	logic [15:0] zeroAddr [10] = '{ADDR_TX_LOW, ADDR_TX_HIGH, ADDR_TX_ERR, ADDR_RX_LOW, ADDR_RX_HIGH,
		ADDR_RX_ERR, ADDR_GRADE, ADDR_PEAK, ADDR_MSE, 16'h0123};
	logic [2:0]  g;

	psq_stats_monitor u_dut (.clock(clock), .resetn(resetn), .regAddr(regAddr), .regRead(regRead),
		.regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid),
		.txPacket(txPacket), .txCrcError(txCrcError), .rxPacket(rxPacket), .rxCrcError(rxCrcError),
		.mseValid(mseValid), .mseSample(mseSample), .peakMseSample(peakMseSample),
		.mediumResetDone(mediumResetDone), .mediumReset(mediumReset));

	psq_attach_model u_attach (.clock(clock), .resetn(resetn), .mediumReset(mediumReset),
		.delayCycles(attachDelay), .mediumResetDone(mediumResetDone));

	// Free-running 50 ns clock
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One read: strobe for one cycle, answer sampled in the following cycle
	task automatic rd(input logic [15:0] addr, input logic [15:0] exp);
		@(posedge clock) #1;
		regRead = 1'b1;
		regAddr = addr;
		@(posedge clock) #1;
		regRead = 1'b0;
		chk({15'h0000, regRdValid}, 16'h0001);
		chk(regRdata, exp);
	endtask

	// Three reads on consecutive cycles; each answer is checked as the next address goes out, the last as the strobe drops
	task automatic rd3(input logic [15:0] a0, input logic [15:0] a1, input logic [15:0] a2,
		input logic [15:0] e0, input logic [15:0] e1, input logic [15:0] e2);
		@(posedge clock) #1;
		regRead = 1'b1;
		regAddr = a0;
		@(posedge clock) #1;
		regAddr = a1;
		chk({15'h0000, regRdValid}, 16'h0001);
		chk(regRdata, e0);
		@(posedge clock) #1;
		regAddr = a2;
		chk({15'h0000, regRdValid}, 16'h0001);
		chk(regRdata, e1);
		@(posedge clock) #1;
		regRead = 1'b0;
		chk({15'h0000, regRdValid}, 16'h0001);
		chk(regRdata, e2);
	endtask

	task automatic wr(input logic [15:0] addr, input logic [15:0] data);
		@(posedge clock) #1;
		regWrite = 1'b1;
		regAddr  = addr;
		regWdata = data;
		@(posedge clock) #1;
		regWrite = 1'b0;
	endtask

	// Packet pulses on consecutive cycles
	task automatic ev(input logic t, input logic te, input logic r, input logic re, input int n);
		repeat (n)
		begin
			@(posedge clock) #1;
			{txPacket, txCrcError, rxPacket, rxCrcError} = {t, te, r, re};
		end
		@(posedge clock) #1;
		{txPacket, txCrcError, rxPacket, rxCrcError} = 4'h0;
	endtask

	task automatic smp(input logic [9:0] m, input logic [7:0] p);
		@(posedge clock) #1;
		mseValid      = 1'b1;
		mseSample     = m;
		peakMseSample = p;
		@(posedge clock) #1;
		mseValid = 1'b0;
	endtask

	// Expected grade straight from the inclusive limits
	function automatic logic [2:0] gradeOf(input int m);
		if (m > 102) return 3'h0;
		if (m > 81) return 3'h1;
		if (m > 65) return 3'h2;
		if (m > 51) return 3'h3;
		if (m > 41) return 3'h4;
		if (m > 32) return 3'h5;
		if (m > 25) return 3'h6;
		return 3'h7;
	endfunction

	task automatic finish_test;
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Watchdog sized well above the long transmit run
	initial
	begin
		repeat (90000) @(posedge clock);
		miscompares++;
		finish_test;
	end

	initial
	begin
		{resetn, regRead, regWrite, txPacket, txCrcError, rxPacket, rxCrcError, mseValid} = 8'h00;
		{regAddr, regWdata, mseSample, peakMseSample, attachDelay} = 58'h0;
		miscompares = 0;
		checked = 0;
		repeat (20) @(posedge clock);
		#1 resetn = 1'b1;
		// Reset values, unmapped read and medium control all read zero
		foreach (zeroAddr[i])
			rd(zeroAddr[i], DATA_ZERO);
		rd(ADDR_MEDIUM, DATA_ZERO);
		$display("test reset values done");
		// 65537 packets wrap both low half and the error counter
		ev(1'b1, 1'b1, 1'b0, 1'b0, 65537);
		rd(ADDR_TX_LOW, 16'h0001);
		rd(ADDR_TX_HIGH, 16'h0001);
		rd(ADDR_TX_ERR, 16'h0001);
		rd(ADDR_TX_LOW, 16'h0000);
		rd(ADDR_TX_HIGH, 16'h0000);
		rd(ADDR_TX_ERR, 16'h0000);
		$display("test transmit counters done");
		// Broken order must not clear; full order must
		ev(1'b0, 1'b0, 1'b1, 1'b0, 5);
		ev(1'b0, 1'b0, 1'b0, 1'b1, 3);
		rd(ADDR_RX_LOW, 16'h0005);
		rd(ADDR_RX_ERR, 16'h0003);
		rd(ADDR_RX_LOW, 16'h0005);
		rd(ADDR_RX_HIGH, 16'h0000);
		rd(ADDR_RX_ERR, 16'h0003);
		rd(ADDR_RX_LOW, 16'h0000);
		rd(ADDR_RX_ERR, 16'h0000);
		// Back-to-back sequence clears too; the error read returns the old count
		ev(1'b0, 1'b0, 1'b1, 1'b1, 2);
		rd3(ADDR_RX_LOW, ADDR_RX_HIGH, ADDR_RX_ERR, 16'h0002, 16'h0000, 16'h0002);
		rd(ADDR_RX_LOW, 16'h0000);
		rd(ADDR_RX_ERR, 16'h0000);
		$display("test receive counters done");
		// Every grade boundary from both sides
		foreach (mseList[i])
		begin
			g = gradeOf(mseList[i]);
			smp(mseList[i][9:0], mseList[i][7:0]);
			rd(ADDR_GRADE, {8'h00, g, 1'b0, g, 1'b0});
			rd(ADDR_MSE, {6'h00, mseList[i][9:0]});
		end
		rd(ADDR_PEAK, 16'h6767);
		$display("test grade mapping done");
		// Worst values track and clear on read
		smp(10'd60, 8'h90);
		smp(10'd30, 8'h20);
		rd(ADDR_GRADE, 16'h006c);
		rd(ADDR_PEAK, 16'h9020);
		rd(ADDR_PEAK, 16'h0020);
		rd(ADDR_GRADE, 16'h000c);
		$display("test worst values done");
		// Bit 15 clear and the printed address are both ignored
		wr(ADDR_MEDIUM, 16'h7fff);
		chk({15'h0000, mediumReset}, 16'h0000);
		// printed form keeps its marker nibble
		wr(ADDR_MEDIUM_PRINTED, 16'h8000);
		chk({15'h0000, mediumReset}, 16'h0000);
		attachDelay = 8'd20;
		wr(ADDR_MEDIUM, 16'h8000);
		chk({15'h0000, mediumReset}, 16'h0001);
		rd(ADDR_MEDIUM, 16'h8000);
		for (int i = 0; i < 40 && mediumReset; i++)
			@(posedge clock) #1;
		chk({15'h0000, mediumReset}, 16'h0000);
		rd(ADDR_MEDIUM, DATA_ZERO);
		attachDelay = 8'd0;
		wr(ADDR_MEDIUM, 16'hffff);
		chk({15'h0000, mediumReset}, 16'h0001);
		@(posedge clock) #1;
		chk({15'h0000, mediumReset}, 16'h0000);
		$display("test medium reset done");
		finish_test;
	end
endmodule
